//--- core/utc_ls_filter.sv
// linestate filter: passes a change after it has held for 2^n clocks
`timescale 1ns/10ps
module utc_ls_filter (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [1:0] raw,
    input  wire logic [3:0] log2n,
    output logic      [1:0] filt
);
    import utc_pkg::*;
    typedef struct packed {
        logic [1:0]  cand;
        logic [1:0]  filt;
        logic [15:0] cnt;
    } utc_flt_st_t;
    utc_flt_st_t s_q, s_d;
    logic [15:0] lim;
    // restart the count on any change, release after the full span
    always_comb begin
        s_d = s_q;
        lim = (16'h0001 << log2n) - 16'h0001;
        if (raw != s_q.cand) begin
            s_d.cand = raw;
            s_d.cnt  = 16'h0000;
        end else if (s_q.cand != s_q.filt) begin
            if (s_q.cnt == lim) begin
                s_d.filt = s_q.cand;
                s_d.cnt  = 16'h0000;
            end else begin
                s_d.cnt = s_q.cnt + 16'h0001;
            end
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) s_q <= '{cand: LS_SE0, filt: LS_SE0, cnt: 16'h0000};
        else        s_q <= s_d;
    end
    assign filt = s_q.filt;
    a_filter_hold: assert property (@(posedge clk) disable iff (!rst_n)
        $changed(s_q.filt) |-> $past(raw == s_q.cand && s_q.cnt == lim))
        else $error("linestate passed before its hold time");
endmodule : utc_ls_filter

//--- core/utc_pkg.sv
// register map, field positions, reset values and codes of the token block
package utc_pkg;
    // register offsets (byte addresses)
    localparam logic [7:0] ADR_DADDR = 8'h08;
    localparam logic [7:0] ADR_SOF   = 8'h28;
    localparam logic [7:0] ADR_PID   = 8'h2c;
    localparam logic [7:0] ADR_EP    = 8'h30;
    localparam logic [7:0] ADR_MATCH = 8'h34;
    localparam logic [7:0] ADR_OTG   = 8'h38;
    localparam logic [7:0] ADR_PWR   = 8'h3c;
    localparam logic [7:0] ADR_PHY   = 8'h40;
    // field widths
    localparam int SOF_W   = 11;
    localparam int PID_W   = 4;
    localparam int EP_W    = 4;
    localparam int DADDR_W = 7;
    localparam int MATCH_W = 16;
    localparam int PWR_W   = 9;
    localparam int FILT_W  = 4;
    localparam int CONF_W  = 3;
    // field positions
    localparam int EP_VALID_BIT  = 4;
    localparam int PWR_VALID_BIT = 8;
    localparam int PHY_PD_DIS    = 18;
    localparam int PHY_RST_FLAG  = 13;
    localparam int PHY_K_FLAG    = 12;
    localparam int PHY_FILT_LSB  = 8;
    localparam int PHY_SUSP_EN   = 7;
    localparam int PHY_CONF_LSB  = 4;
    // reset values
    localparam logic [10:0] RST_SOF   = 11'h000;
    localparam logic [3:0]  RST_PID   = 4'h0;
    localparam logic [3:0]  RST_EP    = 4'h0;
    localparam logic [15:0] RST_MATCH = 16'h0000;
    localparam logic [31:0] RST_OTG   = 32'h0000_0000;
    localparam logic [8:0]  RST_PWR   = 9'h000;
    localparam logic [6:0]  RST_DADDR = 7'h00;
    localparam logic [3:0]  RST_FILT  = 4'h0;
    localparam logic [2:0]  RST_CONF  = 3'h0;
    // endpoint tag added on the receive port
    localparam logic [4:0]  EP_TAG    = 5'h10;
    // token packet identifiers
    localparam logic [3:0]  PID_OUT   = 4'h1;
    localparam logic [3:0]  PID_IN    = 4'h9;
    localparam logic [3:0]  PID_SOF   = 4'h5;
    localparam logic [3:0]  PID_SETUP = 4'hd;
    // token crc and length
    localparam logic [4:0]  CRC5_POLY = 5'h05;
    localparam logic [4:0]  CRC5_INIT = 5'h1f;
    localparam logic [1:0]  TOK_LEN   = 2'h3;
    // line states
    localparam logic [1:0]  LS_SE0    = 2'h0;
    localparam logic [1:0]  LS_J      = 2'h1;
    localparam logic [1:0]  LS_K      = 2'h2;
    // suspend controller states, gray along the path
    typedef enum logic [1:0] {
        SUSP_RUN  = 2'b00,
        SUSP_IDLE = 2'b01,
        SUSP_WAKE = 2'b11,
        SUSP_DONE = 2'b10
    } utc_susp_t;
    // keep a sticky bit unless software writes 0 to it
    function automatic logic utc_keep(input logic cur, input logic wr,
                                      input logic wbit);
        return cur & ~(wr & ~wbit);
    endfunction : utc_keep
endpackage : utc_pkg

//--- core/utc_tok_check.sv
// token receiver: collects pid and two bytes, checks pid and crc5
`timescale 1ns/10ps
module utc_tok_check (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [7:0] rx_data,
    input  wire logic       rx_valid,
    input  wire logic       rx_active,
    output logic            tok_stb,
    output logic      [3:0] tok_pid,
    output logic      [6:0] tok_addr,
    output logic      [3:0] tok_ep,
    output logic     [10:0] tok_frame
);
    import utc_pkg::*;
    typedef struct packed {
        logic        act;
        logic [1:0]  cnt;
        logic        over;
        logic [23:0] buf_b;
        logic        stb;
    } utc_tok_st_t;
    utc_tok_st_t s_q, s_d;
    logic [3:0] pid;
    logic       is_tok;
    // crc5 over the 11 data bits, sent lsb first, crc sent inverted
    function automatic logic crc5_ok(input logic [10:0] d,
                                     input logic [4:0] c_rx);
        logic [4:0] c;
        logic       fb;
        c = CRC5_INIT;
        for (int i = 0; i < 11; i++) begin
            fb = d[i] ^ c[4];
            c  = {c[3:0], 1'b0} ^ (fb ? CRC5_POLY : 5'h00);
        end
        return c_rx == ~{c[0], c[1], c[2], c[3], c[4]};
    endfunction : crc5_ok
    // gather bytes, judge the packet when the receiver goes idle
    always_comb begin
        s_d     = s_q;
        pid     = s_q.buf_b[3:0];
        is_tok  = pid == PID_OUT || pid == PID_IN || pid == PID_SOF
                  || pid == PID_SETUP;
        s_d.act = rx_active;
        s_d.stb = 1'b0;
        if (rx_active && rx_valid) begin
            if (s_q.cnt == TOK_LEN) s_d.over = 1'b1;
            else s_d.cnt = s_q.cnt + 2'h1;
            if (s_q.cnt != TOK_LEN)
                s_d.buf_b[8 * s_q.cnt +: 8] = rx_data;
        end
        if (s_q.act && !rx_active) begin
            s_d.stb  = s_q.cnt == TOK_LEN && !s_q.over && is_tok
                       && s_q.buf_b[7:4] == ~pid
                       && crc5_ok(s_q.buf_b[18:8], s_q.buf_b[23:19]);
            s_d.cnt  = 2'h0;
            s_d.over = 1'b0;
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) s_q <= '0;
        else        s_q <= s_d;
    end
    assign tok_stb   = s_q.stb;
    assign tok_pid   = s_q.buf_b[3:0];
    assign tok_addr  = s_q.buf_b[14:8];
    assign tok_ep    = s_q.buf_b[18:15];
    assign tok_frame = s_q.buf_b[18:8];
endmodule : utc_tok_check

//--- core/utc_top.sv
// token capture, frame counter and phy control registers of the usb unit
//
// Contract
// - eleven-bit frame counter, software read and write
// - capture last received packet identifier, read only
// - capture last received endpoint number, read only
// - endpoint valid flag at bit four
// - masked endpoints leave tagged with 0x10
// - bit eighteen disables data port pulldowns
// - se0 auto-resume sets bit thirteen, writing 0 clears
// - k auto-resume sets bit twelve, writing 0 clears
// - linestate change held two-to-the-n clocks first
// - bit seven lets suspend controller handle resume
// - bits six to four drive phy configuration
// - only tokens for own address pass, frame tokens pass for any address
//
// The address-and-strobe port was decided locally.
`timescale 1ns/10ps
module utc_top (
    input  wire logic        CLK,
    input  wire logic        RST_N,
    input  wire logic [7:0]  ADDR,
    input  wire logic [31:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [31:0] RDATA,
    input  wire logic [7:0]  RX_DATA,
    input  wire logic        RX_VALID,
    input  wire logic        RX_ACTIVE,
    input  wire logic [1:0]  LINESTATE,
    input  wire logic        SUSPEND,
    output logic      [4:0]  TOK_EP,
    output logic             TOK_STB,
    output logic      [1:0]  LINESTATE_FILT,
    output logic             RESUME,
    output logic      [2:0]  PHY_CONFIG_PINS,
    output logic             USB_DATA_PORT_A_PD_EN,
    output logic             USB_DATA_PORT_B_PD_EN,
    output logic      [31:0] OTG_FLAG_MASK,
    output logic      [7:0]  PWR_SIG_DATA,
    output logic             PWR_SIG_VALID
);
    import utc_pkg::*;

    typedef struct packed {
        logic [10:0] sof;
        logic [3:0]  pid;
        logic [3:0]  ep;
        logic        ep_ok;
        logic [15:0] match;
        logic [31:0] otg;
        logic [8:0]  pwr;
        logic [6:0]  daddr;
        logic        pd_dis;
        logic        rst_flag;
        logic        k_flag;
        logic [3:0]  filt_n;
        logic        susp_en;
        logic [2:0]  conf;
        logic [4:0]  tag;
        logic        tag_stb;
        utc_susp_t   st;
        logic [31:0] rdata;
    } utc_top_st_t;

    localparam utc_top_st_t ST_RST = '{
        sof:      RST_SOF,
        pid:      RST_PID,
        ep:       RST_EP,
        ep_ok:    1'b0,
        match:    RST_MATCH,
        otg:      RST_OTG,
        pwr:      RST_PWR,
        daddr:    RST_DADDR,
        pd_dis:   1'b0,
        rst_flag: 1'b0,
        k_flag:   1'b0,
        filt_n:   RST_FILT,
        susp_en:  1'b0,
        conf:     RST_CONF,
        tag:      5'h00,
        tag_stb:  1'b0,
        st:       SUSP_RUN,
        rdata:    32'h0000_0000
    };

    utc_top_st_t s_q, s_d;

    logic        tk_stb;
    logic [3:0]  tk_pid;
    logic [6:0]  tk_addr;
    logic [3:0]  tk_ep;
    logic [10:0] tk_frame;
    logic        tk_sof;
    logic        tk_pass;
    logic [1:0]  ls_filt;
    logic        wr_phy;
    logic        wake_se0;
    logic        wake_k;

    // token framing and crc5 check
    utc_tok_check u_tok (
        .clk       (CLK),
        .rst_n     (RST_N),
        .rx_data   (RX_DATA),
        .rx_valid  (RX_VALID),
        .rx_active (RX_ACTIVE),
        .tok_stb   (tk_stb),
        .tok_pid   (tk_pid),
        .tok_addr  (tk_addr),
        .tok_ep    (tk_ep),
        .tok_frame (tk_frame)
    );

    // linestate filter with programmable hold time
    utc_ls_filter u_flt (
        .clk   (CLK),
        .rst_n (RST_N),
        .raw   (LINESTATE),
        .log2n (s_q.filt_n),
        .filt  (ls_filt)
    );

    // token acceptance: frame tokens are broadcast, others need the address
    assign tk_sof   = tk_pid == PID_SOF;
    assign tk_pass  = tk_stb && (tk_sof || tk_addr == s_q.daddr);
    assign wr_phy   = WR && ADDR == ADR_PHY;
    // a wake only counts while the controller is still enabled, so the
    // cause flags never set on the cycle that leaves idle for run
    assign wake_se0 = s_q.st == SUSP_IDLE && s_q.susp_en
                      && ls_filt == LS_SE0;
    assign wake_k   = s_q.st == SUSP_IDLE && s_q.susp_en
                      && ls_filt == LS_K;

    // register writes, token capture, suspend controller and read port
    always_comb begin
        s_d         = s_q;
        s_d.tag_stb = 1'b0;
        s_d.rdata   = 32'h0000_0000;
        if (WR) begin
            unique case (ADDR)
                ADR_DADDR: s_d.daddr = WDATA[DADDR_W-1:0];
                ADR_SOF:   s_d.sof   = WDATA[SOF_W-1:0];
                ADR_MATCH: s_d.match = WDATA[MATCH_W-1:0];
                ADR_OTG:   s_d.otg   = WDATA;
                ADR_PWR:   s_d.pwr   = WDATA[PWR_W-1:0];
                ADR_PHY: begin
                    s_d.pd_dis  = WDATA[PHY_PD_DIS];
                    s_d.filt_n  = WDATA[PHY_FILT_LSB +: FILT_W];
                    s_d.susp_en = WDATA[PHY_SUSP_EN];
                    s_d.conf    = WDATA[PHY_CONF_LSB +: CONF_W];
                end
                default: ;
            endcase
        end
        // resume cause flags: a wake in the write cycle still sets them
        s_d.rst_flag = wake_se0
            || utc_keep(s_q.rst_flag, wr_phy, WDATA[PHY_RST_FLAG]);
        s_d.k_flag   = wake_k
            || utc_keep(s_q.k_flag, wr_phy, WDATA[PHY_K_FLAG]);
        // accepted token: capture all fields in the same cycle
        if (tk_pass) begin
            s_d.pid = tk_pid;
            if (tk_sof) begin
                s_d.sof   = tk_frame; // frame token beats a software write
                s_d.ep_ok = 1'b0;
            end else begin
                s_d.ep      = tk_ep;
                s_d.ep_ok   = 1'b1;
                s_d.tag     = {1'b0, tk_ep}
                              | (s_q.match[tk_ep] ? EP_TAG : 5'h00);
                s_d.tag_stb = 1'b1;
            end
        end
        // suspend controller: wakes on filtered k or se0 when enabled
        unique case (s_q.st)
            SUSP_RUN:
                if (s_q.susp_en && SUSPEND) s_d.st = SUSP_IDLE;
            SUSP_IDLE:
                if (!s_q.susp_en) s_d.st = SUSP_RUN;
                else if (wake_se0 || wake_k) s_d.st = SUSP_WAKE;
            SUSP_WAKE:
                s_d.st = SUSP_DONE;
            SUSP_DONE:
                if (!SUSPEND) s_d.st = SUSP_RUN;
        endcase
        // read data stand in the cycle after the strobe only
        if (RD) begin
            case (ADDR)
                ADR_DADDR: s_d.rdata[DADDR_W-1:0] = s_q.daddr;
                ADR_SOF:   s_d.rdata[SOF_W-1:0]   = s_q.sof;
                ADR_PID:   s_d.rdata[PID_W-1:0]   = s_q.pid;
                ADR_EP: begin
                    s_d.rdata[EP_W-1:0]      = s_q.ep;
                    s_d.rdata[EP_VALID_BIT]  = s_q.ep_ok;
                end
                ADR_MATCH: s_d.rdata[MATCH_W-1:0] = s_q.match;
                ADR_OTG:   s_d.rdata              = s_q.otg;
                ADR_PWR:   s_d.rdata[PWR_W-1:0]   = s_q.pwr;
                ADR_PHY: begin
                    s_d.rdata[PHY_PD_DIS]   = s_q.pd_dis;
                    s_d.rdata[PHY_RST_FLAG] = s_q.rst_flag;
                    s_d.rdata[PHY_K_FLAG]   = s_q.k_flag;
                    s_d.rdata[PHY_FILT_LSB +: FILT_W] = s_q.filt_n;
                    s_d.rdata[PHY_SUSP_EN]  = s_q.susp_en;
                    s_d.rdata[PHY_CONF_LSB +: CONF_W] = s_q.conf;
                end
                default: s_d.rdata = 32'h0000_0000;
            endcase
        end
    end

    // state register, synchronous reset
    always_ff @(posedge CLK) begin
        if (!RST_N) s_q <= ST_RST;
        else        s_q <= s_d;
    end

    // outputs
    assign RDATA                 = s_q.rdata;
    assign TOK_EP                = s_q.tag;
    assign TOK_STB               = s_q.tag_stb;
    assign LINESTATE_FILT        = ls_filt;
    assign RESUME                = s_q.st == SUSP_WAKE;
    assign PHY_CONFIG_PINS       = s_q.conf;
    assign USB_DATA_PORT_A_PD_EN = !s_q.pd_dis;
    assign USB_DATA_PORT_B_PD_EN = !s_q.pd_dis;
    assign OTG_FLAG_MASK         = s_q.otg;
    assign PWR_SIG_DATA          = s_q.pwr[7:0];
    assign PWR_SIG_VALID         = s_q.pwr[PWR_VALID_BIT];

    // checks of the register and token behaviour
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    a_sof_write: assert property (
        WR && ADDR == ADR_SOF && !(tk_pass && tk_sof)
        ##1 RD && ADDR == ADR_SOF && !(tk_pass && tk_sof)
        |=> RDATA == {21'h0, $past(WDATA[10:0], 2)})
        else $error("frame counter write not read back");

    a_pid_capture: assert property (
        tk_pass ##1 RD && ADDR == ADR_PID
        |=> RDATA == {28'h0, $past(tk_pid, 2)})
        else $error("packet identifier not captured");

    a_ep_capture: assert property (
        tk_pass && !tk_sof ##1 RD && ADDR == ADR_EP
        |=> RDATA == {27'h0, 1'b1, $past(tk_ep, 2)})
        else $error("endpoint or valid flag not captured");

    a_ep_valid_sof: assert property (
        tk_pass && tk_sof ##1 RD && ADDR == ADR_EP |=> !RDATA[4])
        else $error("valid flag set by a frame token");

    a_tag_or: assert property (
        tk_pass && !tk_sof |=> TOK_STB
        && TOK_EP == {$past(s_q.match[tk_ep]), $past(tk_ep)})
        else $error("endpoint tag wrong on the receive port");

    a_pulldown: assert property (
        wr_phy |=> USB_DATA_PORT_A_PD_EN == !$past(WDATA[18])
        && USB_DATA_PORT_B_PD_EN == !$past(WDATA[18]))
        else $error("pulldown control does not follow bit 18");

    a_flag_se0: assert property (
        wake_se0 |=> s_q.rst_flag && RESUME ##1 !RESUME)
        else $error("se0 resume flag or pulse wrong");

    a_flag_sticky: assert property (
        s_q.k_flag && !(wr_phy && !WDATA[12]) |=> s_q.k_flag)
        else $error("k resume flag lost without a clear");

    a_resume_gate: assert property (
        !s_q.susp_en && s_q.st == SUSP_RUN |=> s_q.st == SUSP_RUN)
        else $error("suspend controller active while disabled");

    a_conf_pins: assert property (
        wr_phy |=> PHY_CONFIG_PINS == $past(WDATA[6:4]))
        else $error("configuration pins do not follow the write");

    a_addr_filter: assert property (
        tk_stb && !tk_sof && tk_addr != s_q.daddr
        |=> !TOK_STB && $stable(s_q.pid))
        else $error("token for another address passed");

    a_token_atomic: assert property (
        $changed(s_q.ep) |-> $past(tk_pass) && s_q.pid == $past(tk_pid))
        else $error("endpoint changed without its identifier");

    c_token_in: cover property (tk_pass && tk_pid == PID_IN);
    c_token_sof: cover property (tk_pass && tk_sof);
    c_resume_k: cover property (wake_k ##1 RESUME);
    c_resume_se0: cover property (wake_se0 ##1 s_q.rst_flag);
endmodule : utc_top

//--- verification/tb_utc_top.sv
// testbench of the token capture and phy control block
`timescale 1ns/10ps
module tb_utc_top;
    import utc_pkg::*;
    typedef struct packed {
        logic [7:0]  a;
        logic [31:0] w;
        logic [31:0] r;
    } utc_row_t;
    logic        clk;
    logic        rst_n;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic [31:0] rdata;
    logic [7:0]  rx_data;
    logic        rx_valid;
    logic        rx_active;
    logic [1:0]  ls;
    logic        susp;
    logic [4:0]  tok_ep;
    logic        tok_stb;
    logic [1:0]  ls_filt;
    logic        resume;
    logic [2:0]  conf;
    logic        pd_a;
    logic        pd_b;
    logic [31:0] otg;
    logic [7:0]  pwr;
    logic        pwr_v;
    int          n_fail;
    int          n_compared;
    int          cnt;
    logic [31:0] v;
    utc_row_t    rows [9];

    utc_top utc_top_inst (
        .CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr),
        .RD(rd), .RDATA(rdata), .RX_DATA(rx_data), .RX_VALID(rx_valid),
        .RX_ACTIVE(rx_active), .LINESTATE(ls), .SUSPEND(susp),
        .TOK_EP(tok_ep), .TOK_STB(tok_stb), .LINESTATE_FILT(ls_filt),
        .RESUME(resume), .PHY_CONFIG_PINS(conf),
        .USB_DATA_PORT_A_PD_EN(pd_a), .USB_DATA_PORT_B_PD_EN(pd_b),
        .OTG_FLAG_MASK(otg), .PWR_SIG_DATA(pwr), .PWR_SIG_VALID(pwr_v)
    );

    utc_phy_model utc_phy_model_inst (
        .clk(clk), .rx_data(rx_data), .rx_valid(rx_valid),
        .rx_active(rx_active), .linestate(ls), .suspend(susp)
    );

    // 100 ns clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
            n_fail++;
        end
    endtask : chk

    // one-cycle write strobe
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    // one-cycle read strobe, data taken in the following cycle
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask : rd_reg

    task automatic done(input string s);
        $display("test %s done", s);
    endtask : done

    task automatic results;
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : results

    // send a token, count strobes, then read identifier and endpoint
    task automatic tok(input logic [3:0] pid, input logic [6:0] ad,
                       input logic [3:0] ep, input int gap, input logic bad,
                       input int n_exp, input logic [4:0] ep_exp,
                       input logic [31:0] pid_exp, input logic [31:0] m);
        int         n;
        logic [4:0] seen;
        n = 0;
        seen = 5'h00;
        utc_phy_model_inst.send(pid, ad, ep, gap, bad);
        repeat (8) begin
            @(posedge clk);
            #1;
            if (tok_stb === 1'b1) begin
                n++;
                seen = tok_ep;
            end
        end
        chk(32'(n), 32'(n_exp));
        if (n_exp > 0) chk({27'h0, seen}, {27'h0, ep_exp});
        rd_reg(ADR_PID, v);
        chk(v, pid_exp);
        rd_reg(ADR_EP, v);
        chk(v & m, {27'h0, (n_exp > 0) ? {1'b1, ep} : ep_exp} & m);
    endtask : tok

    // arm suspend, signal on the line, count wake pulses, read flags
    task automatic susp_case(input logic [31:0] ctl, input logic [1:0] lv,
                             input int n_exp, input logic [31:0] r_exp);
        wr_reg(ADR_PHY, ctl);
        utc_phy_model_inst.set_line(LS_J);
        repeat (4) @(posedge clk);
        utc_phy_model_inst.set_susp(1'b1);
        repeat (4) @(posedge clk);
        utc_phy_model_inst.set_line(lv);
        cnt = 0;
        repeat (12) begin
            @(posedge clk);
            #1;
            if (resume === 1'b1) cnt++;
        end
        utc_phy_model_inst.set_susp(1'b0);
        chk(32'(cnt), 32'(n_exp));
        rd_reg(ADR_PHY, v);
        chk(v, r_exp);
    endtask : susp_case

    // watchdog
    initial begin
        repeat (6000) @(posedge clk);
        $display("ERROR %0t: watchdog expired", $time);
        n_fail++;
        results();
    end

    // main sequence
    initial begin
        n_fail = 0;
        n_compared = 0;
        rst_n = 1'b0;
        addr = 8'h00;
        wdata = 32'h0;
        wr = 1'b0;
        rd = 1'b0;
        rows = '{'{ADR_SOF, 32'hffff_ffff, 32'h0000_07ff},
                 '{ADR_PID, 32'hffff_ffff, 32'h0000_0000},
                 '{ADR_EP, 32'hffff_ffff, 32'h0000_0000},
                 '{ADR_MATCH, 32'hffff_ffff, 32'h0000_ffff},
                 '{ADR_OTG, 32'ha5a5_5a5a, 32'ha5a5_5a5a},
                 '{ADR_PWR, 32'hffff_ffff, 32'h0000_01ff},
                 '{ADR_DADDR, 32'hffff_ffff, 32'h0000_007f},
                 '{8'h44, 32'hffff_ffff, 32'h0000_0000},
                 '{ADR_PHY, 32'h0004_3350, 32'h0004_0350}};
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        // table of register writes and read-backs
        foreach (rows[i]) begin
            wr_reg(rows[i].a, rows[i].w);
            rd_reg(rows[i].a, v);
            chk(v, rows[i].r);
        end
        chk({30'h0, pd_a, pd_b}, 32'h0);
        chk({29'h0, conf}, 32'h5);
        chk(otg, 32'ha5a5_5a5a);
        chk({23'h0, pwr_v, pwr}, 32'h1ff);
        done("registers");
        // reset in mid-run clears everything
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk({30'h0, pd_a, pd_b}, 32'h3);
        @(posedge clk);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            rd_reg(rows[i].a, v);
            chk(v, 32'h0);
        end
        chk({27'h0, tok_ep}, 32'h0);
        done("reset");
        // tokens: accepted, slow, tagged, refused ones, then a frame token
        wr_reg(ADR_DADDR, 32'h2a);
        wr_reg(ADR_MATCH, 32'h8008);
        tok(PID_OUT, 7'h2a, 4'h3, 0, 0, 1, 5'h13, 32'h1, 32'h1f);
        tok(PID_IN, 7'h2a, 4'h5, 2, 0, 1, 5'h05, 32'h9, 32'h1f);
        tok(PID_SETUP, 7'h2a, 4'hf, 1, 0, 1, 5'h1f, 32'hd, 32'h1f);
        tok(PID_IN, 7'h2b, 4'h5, 0, 0, 0, 5'h1f, 32'hd, 32'h1f);
        tok(PID_IN, 7'h2a, 4'h5, 0, 1, 0, 5'h1f, 32'hd, 32'h1f);
        tok(4'h3, 7'h2a, 4'h5, 0, 0, 0, 5'h1f, 32'hd, 32'h1f);
        tok(PID_SOF, 7'h23, 4'hb, 0, 0, 0, 5'h00, 32'h5, 32'h10);
        rd_reg(ADR_SOF, v);
        chk(v, 32'h5a3);
        done("tokens");
        // filter: change passes after 2^2+1 edges, short glitch is dropped
        wr_reg(ADR_PHY, 32'h200);
        utc_phy_model_inst.set_line(LS_K);
        cnt = 0;
        while (ls_filt !== LS_K && cnt < 40) begin
            @(posedge clk);
            #1;
            cnt++;
        end
        chk(32'(cnt), 32'h5);
        utc_phy_model_inst.set_line(LS_J);
        repeat (2) @(posedge clk);
        utc_phy_model_inst.set_line(LS_K);
        cnt = 0;
        repeat (12) begin
            @(posedge clk);
            #1;
            if (ls_filt !== LS_K) cnt++;
        end
        chk(32'(cnt), 32'h0);
        done("filter");
        // suspend controller: k wake, sticky flag, se0 wake, disabled
        susp_case(32'h80, LS_K, 1, 32'h1080);
        wr_reg(ADR_PHY, 32'h1080);
        rd_reg(ADR_PHY, v);
        chk(v, 32'h1080);
        wr_reg(ADR_PHY, 32'h80);
        rd_reg(ADR_PHY, v);
        chk(v, 32'h80);
        susp_case(32'h80, LS_SE0, 1, 32'h2080);
        wr_reg(ADR_PHY, 32'h0);
        rd_reg(ADR_PHY, v);
        chk(v, 32'h0);
        susp_case(32'h0, LS_K, 0, 32'h0);
        done("suspend");
        results();
    end
endmodule : tb_utc_top

//--- verification/utc_phy_model.sv
// behavioural phy: token packets, line state and suspend indication
`timescale 1ns/10ps
module utc_phy_model
    import utc_pkg::*;
(
    input  wire logic       clk,
    output logic      [7:0] rx_data,
    output logic            rx_valid,
    output logic            rx_active,
    output logic      [1:0] linestate,
    output logic            suspend
);
    // idle levels at time zero
    initial begin
        rx_data   = 8'h00;
        rx_valid  = 1'b0;
        rx_active = 1'b0;
        linestate = LS_J;
        suspend   = 1'b0;
    end

    // token crc over eleven bits, lsb first, result inverted
    function automatic logic [4:0] crc5_of(input logic [10:0] d);
        logic [4:0] c;
        logic       fb;
        c = CRC5_INIT;
        for (int i = 0; i < 11; i++) begin
            fb = d[i] ^ c[4];
            c = {c[3:0], 1'b0};
            if (fb) c = c ^ CRC5_POLY;
        end
        return ~c;
    endfunction : crc5_of

    // three-byte token; gap idles rx_valid after each byte, bad spoils crc
    task automatic send(input logic [3:0] pid, input logic [6:0] ad,
                        input logic [3:0] ep, input int gap,
                        input logic bad);
        logic [7:0] b [3];
        logic [4:0] c;
        c = crc5_of({ep, ad}) ^ {4'h0, bad};
        b[0] = {~pid, pid};
        b[1] = {ep[0], ad};
        b[2] = {c[0], c[1], c[2], c[3], c[4], ep[3:1]};
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            rx_active <= 1'b1;
            rx_valid  <= 1'b1;
            rx_data   <= b[i];
            repeat (gap) begin
                @(posedge clk);
                rx_valid <= 1'b0;
                rx_data  <= ~b[i]; // stale byte is not held
            end
        end
        @(posedge clk);
        rx_active <= 1'b0;
        rx_valid  <= 1'b0;
        rx_data   <= ~b[2];
    endtask : send

    // bus signalling: k resume or se0 reset as the far side sends it
    task automatic set_line(input logic [1:0] v);
        @(posedge clk);
        linestate <= v;
    endtask : set_line

    // link idle indication that arms the suspend controller
    task automatic set_susp(input logic s);
        @(posedge clk);
        suspend <= s;
    endtask : set_susp
endmodule : utc_phy_model
